/* File: logic/cidf_defines.svh */
// Constants for the CAN identifier filter and byte selector.
`ifndef CIDF_DEFINES_SVH
`define CIDF_DEFINES_SVH
`define CIDF_CLK_MHZ 250
`define CIDF_DWELL_US 1000
`define CIDF_DWELL_CYC (`CIDF_DWELL_US * `CIDF_CLK_MHZ)
`define CIDF_STD_MAX 29'h00007ff
`define CIDF_EXT_MAX 29'h1fffffff
`define CIDF_WILD_BYTE 8'hff
`define CIDF_RATE_50K 3'h0
`define CIDF_RATE_100K 3'h1
`define CIDF_RATE_125K 3'h2
`define CIDF_RATE_250K 3'h3
`define CIDF_RATE_500K 3'h4
`define CIDF_RATE_AUTO 3'h5
`define CIDF_RATE_LAST 3'h4
`endif

/* File: logic/cidf_pkg.sv */
// Types for the CAN identifier filter and byte selector.
package cidf_pkg;
  // Bit-rate controller states, one-hot.
  typedef enum logic [3:0] {
    CIDF_OFF = 4'h1,
    CIDF_FIXED = 4'h2,
    CIDF_HUNT = 4'h4,
    CIDF_LOCK = 4'h8
  } cidf_rate_e;
endpackage

/* File: logic/cidf_filter.sv */
// CAN receive acceptance filter, byte selector and little-endian packer.
`timescale 1ns/100ps
`include "cidf_defines.svh"
module cidf_filter
  import cidf_pkg::*;
#(
  parameter int DWELL_CYC = `CIDF_DWELL_CYC
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic usbAttached,
  input wire logic deepSleep,
  input wire logic [2:0] cfgRate,
  input wire logic cfgExt,
  input wire logic [28:0] cfgId,
  input wire logic [7:0] cfgMask,
  input wire logic busActivity,
  input wire logic frameValid,
  input wire logic frameExt,
  input wire logic [28:0] frameId,
  input wire logic [63:0] frameData,
  output logic busEnable_reg,
  output logic [2:0] rateSel_reg,
  output logic rateLocked_reg,
  output logic recValid_reg,
  output logic [28:0] recId_reg,
  output logic [63:0] recData_reg,
  output logic [3:0] recCount_reg
);

  // Controller state and its next value.
  cidf_rate_e state_reg;
  cidf_rate_e state_next;
  // Dwell counter used while hunting for a bit rate or checking a lock.
  logic [31:0] dwell_reg;
  logic [31:0] dwell_next;
  logic [2:0] rateSel_next;
  // Dwell expired on this cycle.
  wire dwellDone = (dwell_reg == 32'(DWELL_CYC - 1));
  // Bus may run only when no cable and not asleep.
  wire busAllowed = !usbAttached && !deepSleep;
  wire autoSel = (cfgRate == `CIDF_RATE_AUTO);
  // Next candidate rate, wrapping after the fastest one.
  wire [2:0] huntNext = (rateSel_reg == `CIDF_RATE_LAST) ? `CIDF_RATE_50K : rateSel_reg + 3'h1;
  // Fixed codes above the autobaud code are clamped to the slowest rate.
  wire [2:0] fixedRate = (cfgRate > `CIDF_RATE_LAST) ? `CIDF_RATE_50K : cfgRate;

  // Identifier compare. Extended ids are viewed as four bytes; an outer byte
  // programmed all-ones matches anything, since those bytes vary per vehicle.
  wire [31:0] cfgWord = {3'h0, cfgId};
  wire [31:0] frmWord = {3'h0, frameId};
  // Top byte can never hold FF within 29 bits, so all five top bits set, with the lower 24 bits nonzero, stand for FF.
  wire topWild = (cfgId[28:24] == 5'h1f) && (cfgId[23:0] != 24'h0);
  wire lowWild = (cfgWord[7:0] == `CIDF_WILD_BYTE);
  wire topHit = topWild || (cfgWord[31:24] == frmWord[31:24]);
  wire lowHit = lowWild || (cfgWord[7:0] == frmWord[7:0]);
  wire midHit = (cfgWord[23:8] == frmWord[23:8]);
  wire extHit = topHit && midHit && lowHit;
  wire stdHit = (frameId[28:11] == 18'h0) && (frameId[10:0] == cfgId[10:0]);
  // Type must agree, then the value.
  wire idHit = (frameExt == cfgExt) && (cfgExt ? extHit : stdHit);
  wire accept = frameValid && busEnable_reg && idHit;

  // Byte packer: selected bytes are compacted, first received lowest.
  logic [63:0] packData;
  logic [3:0] packCount;
  always_comb
  begin
    packData = 64'h0;
    packCount = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      // Only bytes whose mask bit is set are kept.
      if (cfgMask[i])
      begin
        packData[packCount[2:0] * 8 +: 8] = frameData[i * 8 +: 8];
        packCount = packCount + 4'h1;
      end
    end
  end

  // Bit-rate controller next-state logic.
  always_comb
  begin
    state_next = state_reg;
    dwell_next = 32'h0;
    rateSel_next = rateSel_reg;
    unique case (state_reg)
      CIDF_OFF:
      begin
        // Leave the idle state as soon as the bus is allowed.
        if (busAllowed)
        begin
          state_next = autoSel ? CIDF_HUNT : CIDF_FIXED;
          rateSel_next = autoSel ? `CIDF_RATE_50K : fixedRate;
        end
      end
      CIDF_FIXED:
      begin
        // The configured rate is applied directly.
        rateSel_next = fixedRate;
        if (autoSel)
        begin
          state_next = CIDF_HUNT;
        end
      end
      CIDF_HUNT:
      begin
        // Step through the rates until traffic is seen; never gives up.
        if (busActivity)
        begin
          state_next = CIDF_LOCK;
        end
        else if (dwellDone)
        begin
          rateSel_next = huntNext;
        end
        else
        begin
          dwell_next = dwell_reg + 32'h1;
        end
      end
      CIDF_LOCK:
      begin
        // A silent dwell drops the lock and resumes the search from the locked rate.
        if (busActivity)
        begin
          dwell_next = 32'h0;
        end
        else if (dwellDone)
        begin
          state_next = CIDF_HUNT;
        end
        else
        begin
          dwell_next = dwell_reg + 32'h1;
        end
      end
    endcase
    // Manual change of mode or a forbidden bus overrides everything.
    if (!busAllowed)
    begin
      state_next = CIDF_OFF;
      dwell_next = 32'h0;
    end
    else if (!autoSel && state_reg != CIDF_OFF && state_reg != CIDF_FIXED)
    begin
      state_next = CIDF_FIXED;
      rateSel_next = fixedRate;
      dwell_next = 32'h0;
    end
  end

  // Controller registers.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= CIDF_OFF;
      dwell_reg <= 32'h0;
      rateSel_reg <= `CIDF_RATE_50K;
      busEnable_reg <= 1'b0;
      rateLocked_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      dwell_reg <= dwell_next;
      rateSel_reg <= rateSel_next;
      busEnable_reg <= (state_next != CIDF_OFF);
      rateLocked_reg <= (state_next == CIDF_LOCK) || (state_next == CIDF_FIXED);
    end
  end

  // Output record: one-cycle strobe per accepted frame.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      recValid_reg <= 1'b0;
      recId_reg <= 29'h0;
      recData_reg <= 64'h0;
      recCount_reg <= 4'h0;
    end
    else
    begin
      recValid_reg <= accept;
      if (accept)
      begin
        recId_reg <= frameId;
        recData_reg <= packData;
        recCount_reg <= packCount;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A record appears exactly one cycle after a matching frame.
  rec_follows_match_a: assert property (frameValid && busEnable_reg && idHit |=> recValid_reg)
    else $error("matching frame produced no record");
  // No record without a match the cycle before.
  rec_needs_match_a: assert property (recValid_reg |-> $past(accept))
    else $error("record without matching frame");
  // Type mismatch never yields a record.
  type_mismatch_a: assert property (frameValid && frameExt != cfgExt |=> !recValid_reg)
    else $error("frame of wrong id type accepted");
  // Byte count equals the number of mask bits.
  count_is_mask_a: assert property (accept |=> recCount_reg == 4'($countones($past(cfgMask))))
    else $error("byte count differs from mask");
  // Full mask packs data unchanged, first byte lowest.
  full_mask_order_a: assert property (accept && cfgMask == 8'hff |=> recData_reg == $past(frameData))
    else $error("byte order wrong with full mask");
  // Upper four bytes only: they land in the low word.
  upper_mask_pack_a: assert property (accept && cfgMask == 8'hf0
    |=> recData_reg == {32'h0, $past(frameData[63:32])})
    else $error("upper bytes not packed low");
  // Wildcard outer bytes accept any outer value.
  outer_wild_a: assert property (frameValid && busEnable_reg && cfgExt && frameExt
    && cfgId == 29'h1ffee9ff && frameId[23:8] == 16'hfee9 |=> recValid_reg)
    else $error("fuel id with wild outer bytes rejected");
  // Forbidden bus drops the enable within a cycle.
  bus_forbidden_a: assert property (usbAttached || deepSleep |=> !busEnable_reg)
    else $error("bus enabled while cable or sleep");
  // While hunting, silence for a dwell moves to the next rate.
  hunt_steps_a: assert property (state_reg == CIDF_HUNT && dwellDone && !busActivity && busAllowed
    && autoSel |=> rateSel_reg == $past(huntNext))
    else $error("hunt did not advance rate");
  // Fixed mode drives the configured rate.
  fixed_rate_a: assert property (state_reg == CIDF_FIXED && busAllowed && !autoSel
    |=> rateSel_reg == $past(fixedRate))
    else $error("fixed rate not applied");

  cov_accept_c: cover property (accept ##1 recValid_reg);
  cov_hunt_lock_c: cover property (state_reg == CIDF_HUNT ##1 state_reg == CIDF_LOCK);
  cov_lock_lost_c: cover property (state_reg == CIDF_LOCK ##1 state_reg == CIDF_HUNT);
  cov_reject_c: cover property (frameValid && busEnable_reg && !idHit);

endmodule

/* File: dv/cidf_ecu_model.sv */
// Behavioural model of the vehicle control units that send frames on the CAN bus.
`timescale 1ns/100ps
module cidf_ecu_model
(
  input wire logic clk,
  output logic busActivity,
  output logic frameValid,
  output logic frameExt,
  output logic [28:0] frameId,
  output logic [63:0] frameData
);
  // The bus starts quiet, with no frame on offer.
  initial
  begin
    busActivity = 1'b0;
    frameValid = 1'b0;
    frameExt = 1'b0;
    frameId = 29'h0;
    frameData = 64'h0;
  end

  // Offers one frame for one cycle, then inverts the lines so stale data is never valid.
  task automatic send(input logic ext, input logic [28:0] id, input logic [63:0] data);
    @(posedge clk);
    frameValid <= 1'b1;
    frameExt <= ext;
    frameId <= id;
    frameData <= data;
    @(posedge clk);
    frameValid <= 1'b0;
    frameExt <= ~ext;
    frameId <= ~id;
    frameData <= ~data;
  endtask

  // Shows one cycle of traffic, as a control unit talking at the current rate.
  task automatic pulse();
    @(posedge clk);
    busActivity <= 1'b1;
    @(posedge clk);
    busActivity <= 1'b0;
  endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the identifier filter and byte selector.
`timescale 1ns/100ps
module testbench;
  import cidf_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic usbAttached = 1'b0;
  logic deepSleep = 1'b0;
  logic [2:0] cfgRate = 3'h3;
  logic cfgExt = 1'b1;
  logic [28:0] cfgId = 29'h1ffee9ff;
  logic [7:0] cfgMask = 8'hf0;
  logic busActivity, frameValid, frameExt, busEnable_reg, rateLocked_reg, recValid_reg;
  logic [28:0] frameId, recId_reg;
  logic [63:0] frameData, recData_reg;
  logic [2:0] rateSel_reg;
  logic [3:0] recCount_reg;
  int fails = 0;
  int tests_run = 0;

  // The clock runs at 250 MHz.
  always #2 clk = ~clk;

  // The dwell is shortened so that the rate hunt fits a short run.
  cidf_filter #(.DWELL_CYC(8)) u_dut (.clk(clk), .rst_b(rst_b), .usbAttached(usbAttached),
    .deepSleep(deepSleep), .cfgRate(cfgRate), .cfgExt(cfgExt), .cfgId(cfgId),
    .cfgMask(cfgMask), .busActivity(busActivity), .frameValid(frameValid),
    .frameExt(frameExt), .frameId(frameId), .frameData(frameData),
    .busEnable_reg(busEnable_reg), .rateSel_reg(rateSel_reg),
    .rateLocked_reg(rateLocked_reg), .recValid_reg(recValid_reg), .recId_reg(recId_reg),
    .recData_reg(recData_reg), .recCount_reg(recCount_reg));

  // The far side: control units on the bus.
  cidf_ecu_model u_ecu (.clk(clk), .busActivity(busActivity), .frameValid(frameValid),
    .frameExt(frameExt), .frameId(frameId), .frameData(frameData));

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one result against its expected value.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends one frame and checks the record that follows it, or its absence.
  task automatic frame(input logic ext, input logic [28:0] id, input logic [63:0] data,
    input logic hit, input logic [63:0] expData, input logic [3:0] expCnt);
    u_ecu.send(ext, id, data);
    #1;
    check(recValid_reg, hit);
    if (hit)
    begin
      check(recId_reg, id);
      check(recData_reg, expData);
      check(recCount_reg, expCnt);
    end
  endtask

  // Waits a bounded time for the given rate code.
  task automatic wait_rate(input logic [2:0] r);
    int n;
    n = 0;
    while (rateSel_reg !== r && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(rateSel_reg, r);
    check(rateLocked_reg, 1'b0);
    if (n == 40)
      complete_run();
  endtask

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check(busEnable_reg, 1'b0);
    @(posedge clk);
    #1;
    check({busEnable_reg, rateLocked_reg, rateSel_reg}, 5'h1b);
    for (int r = 0; r < 5; r++)
    begin
      @(posedge clk);
      cfgRate <= r[2:0];
      repeat (2) @(posedge clk);
      #1;
      check({rateLocked_reg, rateSel_reg}, {1'b1, r[2:0]});
    end
    // An unused rate code falls back to the slowest fixed rate.
    @(posedge clk);
    cfgRate <= 3'h6;
    repeat (2) @(posedge clk);
    #1;
    check({rateLocked_reg, rateSel_reg}, 4'h8);
    frame(1'b1, 29'h18fee900, 64'h0003842311223344, 1'b1, 64'h38423, 4'h4);
    frame(1'b1, 29'h0cfee9ab, 64'h0003842311223344, 1'b1, 64'h38423, 4'h4);
    frame(1'b1, 29'h18fee800, 64'h0003842311223344, 1'b0, 64'h0, 4'h0);
    frame(1'b0, 29'h000007ff, 64'h0003842311223344, 1'b0, 64'h0, 4'h0);
    @(posedge clk);
    cfgMask <= 8'hff;
    frame(1'b1, 29'h00fee9ff, 64'h8877665544332211, 1'b1, 64'h8877665544332211, 4'h8);
    @(posedge clk);
    cfgExt <= 1'b0;
    cfgId <= 29'h7ff;
    cfgMask <= 8'h81;
    frame(1'b0, 29'h000007ff, 64'h8877665544332211, 1'b1, 64'h8811, 4'h2);
    frame(1'b0, 29'h000007fe, 64'h8877665544332211, 1'b0, 64'h0, 4'h0);
    frame(1'b1, 29'h000007ff, 64'h8877665544332211, 1'b0, 64'h0, 4'h0);
    @(posedge clk);
    usbAttached <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(busEnable_reg, 1'b0);
    frame(1'b0, 29'h000007ff, 64'h8877665544332211, 1'b0, 64'h0, 4'h0);
    @(posedge clk);
    usbAttached <= 1'b0;
    deepSleep <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(busEnable_reg, 1'b0);
    @(posedge clk);
    deepSleep <= 1'b0;
    cfgRate <= 3'h5;
    repeat (2) @(posedge clk);
    #1;
    check(busEnable_reg, 1'b1);
    for (int r = 1; r < 6; r++)
      wait_rate(r == 5 ? 3'h0 : r[2:0]);
    u_ecu.pulse();
    #1;
    check(rateLocked_reg, 1'b1);
    // A silent dwell drops the lock on its last count, not earlier.
    repeat (7) @(posedge clk);
    #1;
    check(rateLocked_reg, 1'b1);
    @(posedge clk);
    #1;
    check(rateLocked_reg, 1'b0);
    complete_run();
  end
endmodule
